// *** logic/mcs_pkg.sv ***
// Shared constants and types for the motion command sequencer.
`default_nettype none
package mcs_pkg;
	// Register word indices; the byte address is four times the index.
	localparam logic [4:0] IDX_CTRL = 5'h00;
	localparam logic [4:0] IDX_FIELD_FIRST = 5'h01;
	localparam logic [4:0] IDX_FIELD_LAST = 5'h06;
	localparam logic [4:0] IDX_STATUS = 5'h10;
	localparam int NUM_CFG = 16;
	localparam int NUM_FIELDS = 6;
	localparam int ADDR_LSB = 2;
	localparam int ADDR_MSB = 6;
	// Direct-data field slots, in the order of the data registers.
	localparam int F_OPTYPE = 0;
	localparam int F_TORQUE = 5;
	localparam logic [31:0] OPTYPE_CONTINUOUS = 32'h0000_0007;
	// Control word layout.
	localparam int CTRL_LEVEL = 0;
	localparam int CTRL_DEST = 1;
	localparam int CTRL_SEL_LO = 4;
	localparam int CTRL_SEL_HI = 7;
	localparam int CTRL_MODE_LO = 8;
	localparam int CTRL_MODE_HI = 9;
	localparam int CTRL_DIR = 10;
	localparam int CTRL_FORGET = 11;
	// Trigger selection codes.
	localparam logic signed [3:0] SEL_DISABLE = 4'sh0;
	localparam logic signed [3:0] SEL_ALL = 4'sh1;
	localparam logic signed [3:0] SEL_MIN = -4'sh6;
	localparam logic [3:0] SEL_BIAS = 4'h6;
	// Homing modes.
	localparam logic [1:0] MODE_TWO = 2'h0;
	localparam logic [1:0] MODE_THREE = 2'h1;
	localparam logic [1:0] MODE_ONEWAY = 2'h2;
	// Status word layout; bit 6 is cleared by writing one.
	localparam int ST_START_ERR = 6;
	// Motion settings word indices.
	localparam int C_ZH_SPEED = 7;
	localparam int C_ZH_START = 8;
	localparam int C_ZH_ACCEL = 9;
	localparam int C_SHARED = 10;
	localparam int C_HM_START = 11;
	localparam int C_HM_SPEED = 12;
	localparam int C_HM_LAST = 13;
	localparam int C_HM_BACK = 14;
	localparam int C_HM_AMOUNT = 15;
	localparam int SH_FILT_LO = 0;
	localparam int SH_FILT_HI = 7;
	localparam int SH_TRQ_LO = 16;
	localparam int SH_TRQ_HI = 29;
	// Reset image of the settings array, highest index first.
	localparam logic [NUM_CFG-1:0][31:0] CFG_RESET = {
		32'h0000_01f4, 32'h0000_01f4, 32'h0000_01f4, 32'h0000_03e8,
		32'h0000_01f4, 32'h03e8_0001, 32'h000f_4240, 32'h0000_01f4,
		32'h0000_1388, 32'h0000_03e8, 32'h000f_4240, 32'h000f_4240,
		32'h0000_03e8, 32'h0000_0000, 32'h0000_0002, 32'h0000_0511};
	// Command codes presented to the trajectory generator.
	typedef enum logic [2:0] {
		CMD_IDLE = 3'h0,
		CMD_STORED = 3'h1,
		CMD_DIRECT = 3'h2,
		CMD_FAST_HOME = 3'h3,
		CMD_SEEK = 3'h4
	} mcs_cmd_t;
	// Motion sequencer states, one-hot.
	typedef enum logic [7:0] {
		ST_IDLE = 8'h01,
		ST_RUN = 8'h02,
		ST_FAST_ORIGIN_REQUEST = 8'h04,
		ST_SEEK = 8'h08,
		ST_PULL = 8'h10,
		ST_ORIGIN = 8'h20,
		ST_CREEP = 8'h40,
		ST_STEPS = 8'h80
	} mcs_state_t;
endpackage : mcs_pkg
`default_nettype wire

// *** logic/mcs_sequencer.sv ***
// Motion command sequencer: direct data, fast homing and sensor homing.
`default_nettype none
module mcs_sequencer (
	input wire logic clk_sys_i,
	input wire logic resetn_i,
	input wire logic hsel_i,
	input wire logic [31:0] haddr_i,
	input wire logic [1:0] htrans_i,
	input wire logic hwrite_i,
	input wire logic [2:0] hsize_i,
	input wire logic [31:0] hwdata_i,
	input wire logic hready_i,
	output logic [31:0] hrdata_o,
	output logic hreadyout_o,
	output logic hresp_o,
	input wire logic servo_on_i,
	input wire logic direct_trigger_input_i,
	input wire logic start_i,
	input wire logic stop_i,
	input wire logic fast_origin_request_i,
	input wire logic electronic_origin_preset_i,
	input wire logic home_request_i,
	input wire logic limit_pos_i,
	input wire logic limit_neg_i,
	input wire logic origin_sensor_i,
	input wire logic step_i,
	input wire logic motion_done_i,
	output logic ready_o,
	output logic move_o,
	output logic in_position_o,
	output logic command_accept_ready_o,
	output logic home_complete_o,
	output logic command_buffer_full_o,
	output logic start_error_o,
	output logic home_set_o,
	output logic exec_strobe_o,
	output logic [31:0] exec_optype_o,
	output logic [31:0] exec_position_o,
	output logic [31:0] exec_speed_o,
	output logic [31:0] exec_rate_o,
	output logic [31:0] exec_decel_o,
	output logic [31:0] exec_torque_o,
	output mcs_pkg::mcs_cmd_t drive_cmd_o,
	output logic drive_dir_o,
	output logic [31:0] drive_speed_o,
	output logic [31:0] drive_start_speed_o,
	output logic [31:0] drive_accel_o,
	output logic [7:0] filter_ms_o,
	output logic [13:0] torque_limit_o
);
	import mcs_pkg::*;

	typedef struct packed {
		logic [NUM_CFG-1:0][31:0] cfg;
		logic [NUM_FIELDS-1:0][31:0] exec;
		logic [NUM_FIELDS-1:0][31:0] buffer;
		logic buf_full;
		logic started;
		logic direct_trigger_input_prev;
		logic origin_prev;
		logic home_prev;
		logic fast_origin_request_prev;
		logic start_prev;
		mcs_state_t state;
		mcs_cmd_t cmd;
		logic dir;
		logic [31:0] speed;
		logic [31:0] vstart;
		logic [31:0] accel;
		logic [31:0] steps;
		logic in_pos;
		logic home_done;
		logic origin_ok;
		logic start_err;
		logic strobe;
		logic home_set;
		logic wr_pend;
		logic wr_ok;
		logic [4:0] wr_idx;
		logic [31:0] rdata;
	} mcs_regs_t;

	mcs_regs_t s;
	mcs_regs_t next_s;

	////////////////////////////////////////////////////////////////////////
	// Combinational decode of status and edges.
	logic ready;
	logic accept_ready;
	logic [31:0] status_word;
	logic direct_trigger_input_rise;
	logic origin_rise;
	logic origin_fall;
	logic limit_ahead;
	logic [NUM_FIELDS-1:0] changed;
	logic [NUM_FIELDS-1:0][31:0] fresh;
	logic signed [3:0] sel;
	logic sel_valid;
	logic sel_hit;
	logic fire;
	logic [2:0] sel_slot;
	logic [1:0] mode;
	logic [4:0] a_idx;
	logic a_ok;

	// Ready only at rest; the accept flag holds at rest or in a run, and needs a free buffer slot.
	assign ready = servo_on_i && (s.state == ST_IDLE);
	assign accept_ready = servo_on_i && !s.buf_full &&
		(s.state == ST_IDLE || s.state == ST_RUN);
	assign status_word = {24'h0, s.origin_ok, s.start_err, s.buf_full,
		s.home_done, accept_ready, s.in_pos, (s.state != ST_IDLE), ready};
	assign direct_trigger_input_rise = direct_trigger_input_i && !s.direct_trigger_input_prev;
	assign origin_rise = origin_sensor_i && !s.origin_prev;
	assign origin_fall = !origin_sensor_i && s.origin_prev;
	assign limit_ahead = s.dir ? limit_pos_i : limit_neg_i;
	assign sel = s.cfg[IDX_CTRL][CTRL_SEL_HI:CTRL_SEL_LO];
	assign mode = s.cfg[IDX_CTRL][CTRL_MODE_HI:CTRL_MODE_LO];
	assign a_idx = haddr_i[ADDR_MSB:ADDR_LSB];
	assign a_ok = (haddr_i[31:ADDR_MSB+1] == 25'h0) &&
		(haddr_i[1:0] == 2'h0);
	// Codes -6..-1 index field slots 0..5.
	assign sel_slot = 3'(4'(sel) + SEL_BIAS);
	assign sel_valid = (sel == SEL_ALL) ||
		(sel >= SEL_MIN && sel < SEL_DISABLE);

	// A pending field write counts as a change only if the value differs.
	// The merged copy lets a change-trigger launch the new value at once.
	genvar g;
	generate
		for (g = 0; g < NUM_FIELDS; g++) begin : g_field
			logic hit;
			assign hit = s.wr_pend && s.wr_ok &&
				(s.wr_idx == 5'(g + 1));
			assign changed[g] = hit && (hwdata_i != s.cfg[g + 1]);
			assign fresh[g] = hit ? hwdata_i : s.cfg[g + 1];
		end
	endgenerate

	// Restart on any change with code one, else only the tied field.
	assign sel_hit = (sel == SEL_ALL) ? (|changed) :
		(sel != SEL_DISABLE && changed[sel_slot]);
	assign fire = s.cfg[IDX_CTRL][CTRL_LEVEL] && sel_valid &&
		servo_on_i && (direct_trigger_input_rise || (s.started && sel_hit));

	////////////////////////////////////////////////////////////////////////
	// Next-state logic.
	always_comb begin
		next_s = s;
		next_s.strobe = 1'b0;
		next_s.home_set = 1'b0;
		next_s.direct_trigger_input_prev = direct_trigger_input_i;
		next_s.origin_prev = origin_sensor_i;
		next_s.home_prev = home_request_i;
		next_s.fast_origin_request_prev = fast_origin_request_i;
		next_s.start_prev = start_i;

		// Bus data phase: store the word captured in the address phase.
		if (s.wr_pend && s.wr_ok) begin
			if (s.wr_idx < 5'(NUM_CFG)) begin
				next_s.cfg[s.wr_idx[3:0]] = hwdata_i;
			end else if (s.wr_idx == IDX_STATUS &&
					hwdata_i[ST_START_ERR]) begin
				next_s.start_err = 1'b0;
			end
		end
		// Software forgets the home, as after a resolution change.
		if (s.wr_pend && s.wr_ok && s.wr_idx == IDX_CTRL &&
				hwdata_i[CTRL_FORGET]) begin
			next_s.origin_ok = 1'b0;
		end
		next_s.cfg[IDX_CTRL][CTRL_FORGET] = 1'b0;

		// Bus address phase; reads are sampled here, writes land next cycle.
		next_s.wr_pend = 1'b0;
		if (hsel_i && htrans_i[1] && hready_i) begin
			next_s.wr_pend = hwrite_i;
			next_s.wr_ok = a_ok;
			next_s.wr_idx = a_idx;
			if (!hwrite_i) begin
				if (!a_ok) begin
					next_s.rdata = 32'h0;
				end else if (a_idx < 5'(NUM_CFG)) begin
					next_s.rdata = s.cfg[a_idx[3:0]];
				end else if (a_idx == IDX_STATUS) begin
					next_s.rdata = status_word;
				end else begin
					next_s.rdata = 32'h0;
				end
			end
		end

		// Level mode off or code zero forgets the armed trigger.
		if (!(s.cfg[IDX_CTRL][CTRL_LEVEL] && sel_valid)) begin
			next_s.started = 1'b0;
		end else if (direct_trigger_input_rise) begin
			next_s.started = 1'b1;
		end

		// Sequencer.
		case (s.state)
			ST_IDLE: begin
				if (fire) begin
					// At rest even the buffer destination applies at once.
					next_s.exec = fresh;
					next_s.strobe = 1'b1;
					next_s.state = ST_RUN;
					next_s.cmd = CMD_DIRECT;
					next_s.in_pos = 1'b0;
					next_s.home_done = 1'b0;
				end else if (ready && fast_origin_request_i &&
						!s.fast_origin_request_prev) begin
					if (electronic_origin_preset_i) begin
						next_s.state = ST_IDLE;
					end else if (!s.origin_ok) begin
						next_s.start_err = 1'b1;
					end else begin
						next_s.state = ST_FAST_ORIGIN_REQUEST;
						next_s.cmd = CMD_FAST_HOME;
						next_s.in_pos = 1'b0;
						next_s.speed = s.cfg[C_ZH_SPEED];
						next_s.vstart = s.cfg[C_ZH_START];
						next_s.accel = s.cfg[C_ZH_ACCEL];
					end
				end else if (ready && home_request_i && !s.home_prev) begin
					next_s.state = ST_SEEK;
					next_s.cmd = CMD_SEEK;
					next_s.in_pos = 1'b0;
					next_s.home_done = 1'b0;
					next_s.dir = s.cfg[IDX_CTRL][CTRL_DIR];
					next_s.vstart = s.cfg[C_HM_START];
					next_s.accel = s.cfg[C_ZH_ACCEL];
					// Two-sensor crawls at the start speed throughout.
					next_s.speed = (mode == MODE_TWO) ?
						s.cfg[C_HM_START] : s.cfg[C_HM_SPEED];
				end else if (ready && start_i && !s.start_prev) begin
					next_s.state = ST_RUN;
					next_s.cmd = CMD_STORED;
					next_s.in_pos = 1'b0;
					next_s.home_done = 1'b0;
				end
			end
			ST_RUN: begin
				// A finishing move launches the buffered set first, so the
				// completion pulse is never lost; a trigger in that cycle is.
				if (motion_done_i && s.buf_full) begin
					next_s.exec = s.buffer;
					next_s.buf_full = 1'b0;
					next_s.strobe = 1'b1;
					next_s.cmd = CMD_DIRECT;
				end else if (fire && !s.cfg[IDX_CTRL][CTRL_DEST]) begin
					if (!s.buf_full) begin
						next_s.exec = fresh;
						next_s.strobe = 1'b1;
						next_s.cmd = CMD_DIRECT;
					end
				end else if (fire) begin
					// A move that ends in this cycle counts as stopped.
					if (motion_done_i ||
							s.exec[F_OPTYPE] == OPTYPE_CONTINUOUS) begin
						next_s.exec = fresh;
						next_s.strobe = 1'b1;
						next_s.cmd = CMD_DIRECT;
					end else begin
						next_s.buffer = fresh;
						next_s.buf_full = 1'b1;
					end
				end else if (motion_done_i) begin
					next_s.state = ST_IDLE;
					next_s.cmd = CMD_IDLE;
					next_s.in_pos = 1'b1;
				end
			end
			ST_FAST_ORIGIN_REQUEST: begin
				if (motion_done_i) begin
					next_s.state = ST_IDLE;
					next_s.cmd = CMD_IDLE;
					next_s.in_pos = 1'b1;
					next_s.home_done = 1'b1;
				end
			end
			ST_SEEK: begin
				if (mode != MODE_ONEWAY && limit_ahead) begin
					next_s.state = ST_PULL;
					next_s.dir = !s.dir;
				end else if (mode == MODE_THREE && origin_rise) begin
					next_s.home_set = 1'b1;
				end else if (mode == MODE_ONEWAY && origin_rise) begin
					next_s.state = ST_CREEP;
					next_s.speed = s.cfg[C_HM_LAST];
				end
			end
			ST_PULL: begin
				// Leaving the limit: the sensor behind us has just cleared.
				if (!(s.dir ? limit_neg_i : limit_pos_i)) begin
					if (mode == MODE_TWO) begin
						next_s.state = ST_STEPS;
						next_s.steps = s.cfg[C_HM_BACK];
					end else begin
						next_s.state = ST_ORIGIN;
					end
				end
			end
			ST_ORIGIN: begin
				if (origin_rise) begin
					next_s.home_set = 1'b1;
				end
			end
			ST_CREEP: begin
				if (origin_fall) begin
					next_s.state = ST_STEPS;
					next_s.steps = s.cfg[C_HM_AMOUNT];
				end
			end
			ST_STEPS: begin
				if (s.steps == 32'h0) begin
					next_s.home_set = 1'b1;
				end else if (step_i) begin
					next_s.steps = s.steps - 32'h1;
				end
			end
			default: begin
				next_s.state = ST_IDLE;
				next_s.cmd = CMD_IDLE;
			end
		endcase

		// Sensor homing ends where it stops; that spot becomes the home.
		if (next_s.home_set) begin
			next_s.state = ST_IDLE;
			next_s.cmd = CMD_IDLE;
			next_s.in_pos = 1'b1;
			next_s.home_done = 1'b1;
			next_s.origin_ok = 1'b1;
		end
		if (s.state == ST_FAST_ORIGIN_REQUEST && motion_done_i) begin
			next_s.origin_ok = 1'b1;
		end

		// Stop or servo off abandons any motion and any buffered set.
		if (stop_i || !servo_on_i) begin
			// A start that would begin under a held stop is refused too.
			if (s.state != ST_IDLE || next_s.state != ST_IDLE) begin
				next_s.state = ST_IDLE;
				next_s.cmd = CMD_IDLE;
				next_s.home_set = 1'b0;
				next_s.home_done = 1'b0;
				next_s.strobe = 1'b0;
			end
			next_s.buf_full = 1'b0;
		end

		// A refused request in this cycle outranks the clear above.
		if (s.state == ST_IDLE && ready && fast_origin_request_i &&
				!s.fast_origin_request_prev && !electronic_origin_preset_i &&
				!s.origin_ok && !fire) begin
			next_s.start_err = 1'b1;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// State register.
	always_ff @(posedge clk_sys_i or negedge resetn_i) begin
		if (!resetn_i) begin
			s <= '0;
			s.cfg <= CFG_RESET;
			s.state <= ST_IDLE;
			s.cmd <= CMD_IDLE;
			s.direct_trigger_input_prev <= 1'b1; // Avoids a false edge if held at reset.
			s.home_prev <= 1'b1;
			s.fast_origin_request_prev <= 1'b1;
			s.start_prev <= 1'b1;
			s.origin_prev <= 1'b1;
		end else begin
			s <= next_s;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Outputs.
	assign hrdata_o = s.rdata;
	assign hreadyout_o = 1'b1; // Zero wait states; response always OKAY.
	assign hresp_o = 1'b0;
	assign ready_o = ready;
	assign move_o = (s.state != ST_IDLE);
	assign in_position_o = s.in_pos;
	assign command_accept_ready_o = accept_ready;
	assign home_complete_o = s.home_done;
	assign command_buffer_full_o = s.buf_full;
	assign start_error_o = s.start_err;
	assign home_set_o = s.home_set;
	assign exec_strobe_o = s.strobe;
	assign exec_optype_o = s.exec[F_OPTYPE];
	assign exec_position_o = s.exec[1];
	assign exec_speed_o = s.exec[2];
	assign exec_rate_o = s.exec[3];
	assign exec_decel_o = s.exec[4];
	assign exec_torque_o = s.exec[F_TORQUE];
	assign drive_cmd_o = s.cmd;
	assign drive_dir_o = s.dir;
	assign drive_speed_o = s.speed;
	assign drive_start_speed_o = s.vstart;
	assign drive_accel_o = s.accel;
	// Shared homing filter and torque limit straight from the settings.
	assign filter_ms_o = s.cfg[C_SHARED][SH_FILT_HI:SH_FILT_LO];
	assign torque_limit_o = s.cfg[C_SHARED][SH_TRQ_HI:SH_TRQ_LO];

	logic unused;
	assign unused = ^{hsize_i, haddr_i[1:0]};
endmodule : mcs_sequencer
`default_nettype wire

// *** test/mcs_far_model.sv ***
// Far-side model: trajectory completion, step pulses and sensors.
`default_nettype none
module mcs_far_model
	import mcs_pkg::*;
#(
	parameter int LAT = 12
) (
	input wire logic clk_sys_i,
	input wire logic resetn_i,
	input wire mcs_pkg::mcs_cmd_t drive_cmd_i,
	input wire logic hold_i,
	output logic motion_done_o,
	output logic origin_sensor_o,
	output logic step_o,
	output logic limit_pos_o,
	output logic limit_neg_o
);
	timeunit 1ns;
	timeprecision 1ps;
	int cnt;
	// Sensors are mapped to terminals; the positive limit and the origin
	// share one toggling track, and the negative limit is never reached.
	assign limit_pos_o = origin_sensor_o;
	assign limit_neg_o = 1'b0;
	// One step per cycle of unstalled travel.
	assign step_o = (drive_cmd_i != CMD_IDLE) && !hold_i;
	// Non-seek travel ends LAT+1 cycles in; a stall holds it off so a move can be
	// kept running for as long as a scenario needs.
	always_ff @(posedge clk_sys_i or negedge resetn_i) begin
		if (!resetn_i) begin
			cnt <= 0;
			motion_done_o <= 1'b0;
			origin_sensor_o <= 1'b0;
		end else begin
			motion_done_o <= 1'b0;
			if (drive_cmd_i == CMD_IDLE) begin
				cnt <= 0;
				origin_sensor_o <= 1'b0;
			end else if (!hold_i) begin
				cnt <= (cnt == LAT) ? 0 : cnt + 1;
				if (cnt == LAT && drive_cmd_i == CMD_SEEK)
					origin_sensor_o <= !origin_sensor_o;
				else if (cnt == LAT)
					motion_done_o <= 1'b1;
			end
		end
	end
endmodule : mcs_far_model
`default_nettype wire

// *** test/mcs_seq_chk_asserts.sv ***
// Port checker for the motion command sequencer, bound to its top.
`default_nettype none
module mcs_seq_chk
	import mcs_pkg::*;
(
	input wire logic clk_sys_i,
	input wire logic resetn_i,
	input wire logic servo_on_i,
	input wire logic stop_i,
	input wire logic electronic_origin_preset_i,
	input wire logic motion_done_i,
	input wire logic ready_o,
	input wire logic move_o,
	input wire logic in_position_o,
	input wire logic command_accept_ready_o,
	input wire logic home_complete_o,
	input wire logic command_buffer_full_o,
	input wire logic start_error_o,
	input wire logic home_set_o,
	input wire logic exec_strobe_o,
	input wire mcs_pkg::mcs_cmd_t drive_cmd_o
);
	timeunit 1ns;
	timeprecision 1ps;
	// One clock domain, so clock and reset are given once.
	default clocking dcb @(posedge clk_sys_i);
	endclocking
	default disable iff (!resetn_i);
	////////////////////////////////////////
	AST_READY: assert property (
		ready_o == (servo_on_i && !move_o))
		else $error("ready does not follow servo on and idle");
	AST_FAST_ACCEPT: assert property (
		drive_cmd_o == CMD_FAST_HOME && $past(drive_cmd_o) != CMD_FAST_HOME
		|-> move_o && !ready_o && !in_position_o && !command_accept_ready_o)
		else $error("fast home start left status outputs wrong");
	AST_PRESET: assert property (
		electronic_origin_preset_i ##1 drive_cmd_o == CMD_FAST_HOME
		|-> $past(drive_cmd_o) == CMD_FAST_HOME)
		else $error("fast home began while preset was on");
	AST_HOME_END: assert property (
		drive_cmd_o == CMD_FAST_HOME && motion_done_i && !stop_i
		&& servo_on_i
		|=> home_complete_o && in_position_o && !move_o
		&& ready_o == servo_on_i && command_accept_ready_o == servo_on_i)
		else $error("home reached without completion outputs");
	AST_START: assert property (
		$rose(drive_cmd_o == CMD_STORED)
		|-> !home_complete_o && !in_position_o && !ready_o && move_o)
		else $error("start did not clear completion outputs");
	AST_BUF_HOLD: assert property (
		command_buffer_full_o && !motion_done_i |=> !exec_strobe_o)
		else $error("data applied while buffer was full");
	AST_BUF_LAUNCH: assert property (
		command_buffer_full_o && motion_done_i && servo_on_i && !stop_i
		|=> exec_strobe_o && !command_buffer_full_o)
		else $error("buffered set not launched at motion end");
	AST_ERR_NOMOVE: assert property (
		$rose(start_error_o) |-> !move_o && drive_cmd_o != CMD_FAST_HOME)
		else $error("start error came with motion");
	AST_SEEK_DONE: assert property (
		home_set_o |-> home_complete_o && in_position_o && !move_o
		&& $past(drive_cmd_o) == CMD_SEEK)
		else $error("home set without seek completion");
	AST_STOP: assert property (
		stop_i && move_o |=> !move_o)
		else $error("stop did not end motion");
	AST_STROBE_MOVE: assert property (
		exec_strobe_o |-> move_o && drive_cmd_o == CMD_DIRECT)
		else $error("direct load without direct motion");
	// Main scenarios the bench is meant to reach.
	cover property (home_set_o);
	cover property (command_buffer_full_o && motion_done_i);
	cover property ($rose(start_error_o));
	cover property (electronic_origin_preset_i && ready_o);
endmodule : mcs_seq_chk
bind mcs_sequencer mcs_seq_chk u_chk (.clk_sys_i, .resetn_i, .servo_on_i,
	.stop_i, .electronic_origin_preset_i, .motion_done_i, .ready_o, .move_o,
	.in_position_o, .command_accept_ready_o, .home_complete_o,
	.command_buffer_full_o, .start_error_o, .home_set_o, .exec_strobe_o,
	.drive_cmd_o);
`default_nettype wire

// *** test/mcs_sequencer_tb.sv ***
// Self-checking testbench for the motion command sequencer.
`default_nettype none
module mcs_sequencer_tb;
	timeunit 1ns;
	timeprecision 1ps;
	import mcs_pkg::*;
	logic clk_sys_i = 1'b0;
	logic resetn_i = 1'b0;
	logic hsel_i = 1'b0;
	logic hwrite_i = 1'b0;
	logic [1:0] htrans_i = 2'h0;
	logic [2:0] hsize_i = 3'h2;
	logic [31:0] haddr_i = 32'h0;
	logic [31:0] hwdata_i = 32'h0;
	logic servo_on_i = 1'b1;
	logic direct_trigger_input_i = 1'b0;
	logic start_i = 1'b0;
	logic stop_i = 1'b0;
	logic fast_origin_request_i = 1'b0;
	logic electronic_origin_preset_i = 1'b0;
	logic home_request_i = 1'b0;
	logic hold = 1'b0;
	logic limit_pos_i, limit_neg_i, origin_sensor_i, step_i, motion_done_i;
	logic [31:0] hrdata_o;
	logic hreadyout_o, hresp_o, ready_o, move_o, in_position_o;
	logic command_accept_ready_o, home_complete_o, command_buffer_full_o;
	logic start_error_o, home_set_o, exec_strobe_o, drive_dir_o;
	logic [7:0] filter_ms_o;
	logic [13:0] torque_limit_o;
	logic [31:0] drive_speed_o, drive_start_speed_o, drive_accel_o;
	mcs_cmd_t drive_cmd_o;
	wire [5:0][31:0] ex;
	int num_errors = 0;
	int n_checks = 0;
	int cyc = 0;
	mcs_sequencer uut (.clk_sys_i, .resetn_i, .hsel_i, .haddr_i, .htrans_i,
		.hwrite_i, .hsize_i, .hwdata_i, .hready_i(hreadyout_o), .hrdata_o,
		.hreadyout_o, .hresp_o, .servo_on_i, .direct_trigger_input_i,
		.start_i, .stop_i, .fast_origin_request_i, .electronic_origin_preset_i,
		.home_request_i, .limit_pos_i, .limit_neg_i, .origin_sensor_i, .step_i,
		.motion_done_i, .ready_o, .move_o, .in_position_o,
		.command_accept_ready_o, .home_complete_o, .command_buffer_full_o,
		.start_error_o, .home_set_o, .exec_strobe_o, .exec_optype_o(ex[0]),
		.exec_position_o(ex[1]), .exec_speed_o(ex[2]), .exec_rate_o(ex[3]),
		.exec_decel_o(ex[4]), .exec_torque_o(ex[5]), .drive_cmd_o,
		.drive_dir_o, .drive_speed_o, .drive_start_speed_o, .drive_accel_o,
		.filter_ms_o, .torque_limit_o);
	mcs_far_model far (.clk_sys_i, .resetn_i, .drive_cmd_i(drive_cmd_o),
		.hold_i(hold), .motion_done_o(motion_done_i),
		.origin_sensor_o(origin_sensor_i), .step_o(step_i),
		.limit_pos_o(limit_pos_i), .limit_neg_o(limit_neg_i));
	////////////////////////////////////////
	// 40 MHz clock and a hang limit far above the run's length of under two thousand cycles.
	always #12.5 clk_sys_i = ~clk_sys_i;
	always @(posedge clk_sys_i) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			num_errors++;
			stop_test();
		end
	end
	task automatic stop_test;
		$display("checks %0d errors %0d", n_checks, num_errors);
		if (num_errors == 0 && n_checks > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask : stop_test
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			num_errors++;
			$display("[ERR] t=%0t got %h exp %h", $time, got, exp);
		end
	endtask : chk
	task automatic tick(input int n);
		repeat (n) @(posedge clk_sys_i);
	endtask : tick
	// One single AHB word transfer; no wait count is assumed.
	task automatic bus(input logic w, input logic [31:0] a, d,
		output logic [31:0] r);
		hsel_i <= 1'b1;
		htrans_i <= 2'h2;
		haddr_i <= a;
		hwrite_i <= w;
		do @(posedge clk_sys_i); while (hreadyout_o !== 1'b1);
		hsel_i <= 1'b0;
		htrans_i <= 2'h0;
		hwdata_i <= d;
		do @(posedge clk_sys_i); while (hreadyout_o !== 1'b1);
		r = hrdata_o;
	endtask : bus
	task automatic wr(input logic [31:0] a, d);
		logic [31:0] r;
		bus(1'b1, a, d, r);
	endtask : wr
	task automatic rdc(input logic [31:0] a, e);
		logic [31:0] r;
		bus(1'b0, a, 32'h0, r);
		chk(r, e);
	endtask : rdc
	task automatic seen(output logic s);
		s = 1'b0;
		repeat (4) begin
			@(posedge clk_sys_i);
			if (exec_strobe_o === 1'b1)
				s = 1'b1;
		end
	endtask : seen
	task automatic fire(output logic s);
		direct_trigger_input_i <= 1'b1;
		seen(s);
		direct_trigger_input_i <= 1'b0;
		tick(1);
	endtask : fire
	task automatic wait_idle;
		for (int i = 0; i < 200 && move_o !== 1'b0; i++)
			@(posedge clk_sys_i);
	endtask : wait_idle
	// Host keeps the request up until it sees ready low, or gives up.
	task automatic fast_req;
		fast_origin_request_i <= 1'b1;
		for (int i = 0; i < 4 && ready_o !== 1'b0; i++)
			@(posedge clk_sys_i);
		fast_origin_request_i <= 1'b0;
	endtask : fast_req
	////////////////////////////////////////
	task automatic t_regs;
		rdc(32'h00, 32'h0000_0511);
		rdc(32'h1c, 32'h0000_1388);
		rdc(32'h20, 32'h0000_01f4);
		rdc(32'h24, 32'h000f_4240);
		rdc(32'h28, 32'h03e8_0001);
		chk(32'(filter_ms_o), 32'h1);
		chk(32'(torque_limit_o), 32'h3e8);
		rdc(32'h40, 32'h09);
		wr(32'h44, 32'hffff_ffff);
		rdc(32'h44, 32'h0);
	endtask : t_regs
	// No home yet, then preset on: both requests must stay motionless.
	task automatic t_refuse;
		fast_req;
		chk({30'h0, start_error_o, move_o}, 32'h2);
		wr(32'h40, 32'h40);
		tick(1);
		chk(32'(start_error_o), 32'h0);
		electronic_origin_preset_i <= 1'b1;
		fast_req;
		chk({30'h0, start_error_o, move_o}, 32'h0);
		electronic_origin_preset_i <= 1'b0;
	endtask : t_refuse
	// Two-sensor, one-way, then three-sensor; only one-way never reverses.
	task automatic t_seek;
		logic [31:0] ctl;
		for (int m = 0; m < 3; m++) begin
			ctl = (m == 0) ? 32'h411 : (m == 1) ? 32'h611 : 32'h511;
			wr(32'h00, ctl);
			home_request_i <= 1'b1;
			tick(2);
			chk(32'(drive_cmd_o), 32'(CMD_SEEK));
			chk(32'(drive_dir_o), 32'h1);
			chk(drive_speed_o, (m == 0) ? 32'h1f4 : 32'h3e8);
			for (int i = 0; i < 700 && home_set_o !== 1'b1; i++)
				@(posedge clk_sys_i);
			chk(32'({home_set_o, home_complete_o, in_position_o, move_o,
				drive_dir_o}), (m == 1) ? 32'h1d : 32'h1c);
			home_request_i <= 1'b0;
			tick(1);
		end
	endtask : t_seek
	task automatic t_fast;
		fast_req;
		chk(32'({move_o, ready_o, in_position_o, command_accept_ready_o}),
			32'h8);
		chk(32'(drive_cmd_o), 32'(CMD_FAST_HOME));
		chk(drive_speed_o, 32'h1388);
		chk(drive_start_speed_o, 32'h1f4);
		chk(drive_accel_o, 32'hf_4240);
		wait_idle;
		chk(32'({home_complete_o, in_position_o, ready_o,
			command_accept_ready_o, move_o}), 32'h1e);
		rdc(32'h40, 32'h9d);
		start_i <= 1'b1;
		tick(2);
		chk(32'({home_complete_o, in_position_o, ready_o, move_o}),
			32'h1);
		start_i <= 1'b0;
		wait_idle;
		hold <= 1'b1;
		fast_req;
		stop_i <= 1'b1;
		tick(2);
		chk(32'({move_o, home_complete_o}), 32'h0);
		stop_i <= 1'b0;
		hold <= 1'b0;
	endtask : t_fast
	// Motion is stalled so every load after the first, which starts from rest, lands on a running operation.
	task automatic t_direct;
		logic s;
		logic [31:0] v;
		hold <= 1'b1;
		fire(s);
		chk(32'(s), 32'h1);
		wr(32'h08, 32'h55);
		seen(s);
		chk({31'h0, s} ^ ex[1], 32'h54);
		wr(32'h08, 32'h55);
		seen(s);
		chk(32'(s), 32'h0);
		for (int k = 1; k <= 6; k++) begin
			v = (k == 6) ? 32'h3 : 32'h100 + 32'(k);
			wr(32'h0, 32'h501 | 32'((16 - k) << 4));
			fire(s);
			chk(32'(s), 32'h1);
			wr((k == 5) ? 32'h0c : 32'h08, 32'h200 + 32'(k));
			seen(s);
			chk(32'(s), 32'h0);
			wr(32'h1c - 32'(4 * k), v);
			seen(s);
			chk({31'h0, s} ^ ex[6-k], v ^ 32'h1);
		end
		wr(32'h0, 32'h501);
		fire(s);
		chk(32'(s), 32'h0);
		wr(32'h0, 32'h510);
		fire(s);
		chk(32'(s), 32'h0);
	endtask : t_direct
	task automatic t_buffer;
		logic s;
		wr(32'h0, 32'h513);
		fire(s);
		chk(32'(s), 32'h0);
		chk(32'({command_buffer_full_o, command_accept_ready_o}),
			32'h2);
		wr(32'h0, 32'h511);
		fire(s);
		chk(32'({s, command_buffer_full_o}), 32'h1);
		hold <= 1'b0;
		for (int i = 0; i < 40 && exec_strobe_o !== 1'b1; i++)
			@(posedge clk_sys_i);
		chk(32'(exec_strobe_o), 32'h1);
		chk(32'(command_buffer_full_o), 32'h0);
		wait_idle;
		wr(32'h0, 32'h513);
		fire(s);
		chk(32'({s, command_buffer_full_o}), 32'h2);
		wait_idle;
	endtask : t_buffer
	// Reset for four cycles, then run every scenario in turn.
	initial begin
		tick(4);
		resetn_i <= 1'b1;
		tick(1);
		t_regs();
		t_refuse();
		t_seek();
		t_fast();
		t_direct();
		t_buffer();
		stop_test();
	end
endmodule : mcs_sequencer_tb
`default_nettype wire
